/* File: tmfr_pkg.sv */
// Package for translation-miss fault reporting: vectors, syndrome layout, register offsets.
// Assumes a 64-bit virtual address and region registers supplied by the core.
package tmfr_pkg;
  // Vector offsets
  localparam logic [15:0] VEC_INSTR_MISS = 16'h0400;
  localparam logic [15:0] VEC_DATA_MISS = 16'h0800;
  localparam logic [15:0] VEC_ALT_INSTR = 16'h0c00;
  localparam logic [15:0] VEC_NESTED_DATA = 16'h1400;
  // Syndrome field positions
  localparam int SYN_CODE_LO = 0;
  localparam int SYN_X = 32;
  localparam int SYN_W = 33;
  localparam int SYN_R = 34;
  localparam int SYN_NA = 35;
  localparam int SYN_SP = 36;
  localparam int SYN_RS = 37;
  localparam int SYN_IR = 38;
  localparam int SYN_NI = 39;
  localparam int SYN_EI_LO = 41;
  localparam int SYN_ED = 43;
  // Default translation info field positions
  localparam int DTI_PS_LO = 2;
  localparam int DTI_KEY_LO = 8;
  // Legacy instruction alignment mask (16 bytes)
  localparam logic [63:0] LEGACY_ALIGN_MASK = 64'hffff_ffff_ffff_fff0;
  localparam logic [63:0] LEGACY_ADDR_MASK = 64'h0000_0000_ffff_ffff;
  // Register word indices
  localparam logic [3:0] REG_SYNDROME = 4'h0;
  localparam logic [3:0] REG_FAULT_ADDR = 4'h1;
  localparam logic [3:0] REG_HASHED_ADDR = 4'h2;
  localparam logic [3:0] REG_DEF_TRANS = 4'h3;
  localparam logic [3:0] REG_VECTOR = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  // Collection state encoding
  typedef enum logic [1:0] {
    TMFR_IC_OFF = 2'b00,
    TMFR_IC_ON = 2'b01,
    TMFR_IC_FLIGHT = 2'b10
  } tmfr_ic_t;
  // Miss request from the fetch/load-store pipeline
  typedef struct packed {
    logic valid;
    logic is_instr;
    logic legacy;
    logic [63:0] vaddr;
    logic [63:0] hash_addr;
    logic walker_fail;
    logic will_exec;
    logic [1:0] slot;
    logic is_load;
    logic is_store;
    logic is_sema;
    logic is_nonaccess;
    logic [3:0] na_code;
    logic is_stack;
    logic speculative;
  } tmfr_req_t;
  // Region register contents selected by the address
  typedef struct packed {
    logic [23:0] region_id;
    logic [5:0] region_page_size;
    logic walker_en;
  } tmfr_region_t;
endpackage : tmfr_pkg

/* File: tmfr_fault.sv */
// Translation-miss fault selection and interruption state capture.
// Assumes the pipeline presents one miss request a cycle and the region lookup is combinational.
// Operation
// - Instruction miss with walker enabled but failed goes to vector 0x0400.
// - Data miss with walker failed goes to vector 0x0800.
// - Instruction miss with walker disabled goes to alternate vector 0x0c00.
// - Walker-backed faults load hashed entry address of the faulting reference.
// - Default translation key field gets region id of the selected region.
// - Default page size copies region page size; other fields zero.
// - Instruction fault address is bundle address; legacy aligned to 16, zero-extended.
// - Data fault address is the referenced data address.
// - Walker-backed faults: not_collected 0 if collection on, 1 if in flight.
// - Instruction faults set slot index; legacy forces slot and not_collected zero.
// - Non-access data faults put instruction type in code bits, else zero.
// - Register-stack fill or spill faults always clear exception deferral.
// - Legacy data references zero code, deferral, slot, stack, speculative, non-access.
// - Instruction faults set execute bit 32; data faults report write 33, read 34.
// - Instruction miss needs collection on/in flight, walker, translation on, execute.
// - Data miss needs load/store/semaphore/non-access, data translation, walker enabled.
// - Register-stack references need stack translation on and walker enabled.
// - Data miss only with collection on/in flight, else nested data fault.
// - Alternate native fault: not_collected 0 if collection on, else 1.
// - Alternate instruction fault needs walker disabled and bundle to execute.
// - Walker may fail for many reasons; any failure reports a miss.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module tmfr_fault (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Miss request and region lookup
  input wire tmfr_pkg::tmfr_req_t i_req,
  input wire tmfr_pkg::tmfr_region_t i_region,
  // Processor state
  input wire tmfr_pkg::tmfr_ic_t i_collection,
  input wire logic i_instr_translation_on,
  input wire logic i_data_translation_on,
  input wire logic i_stack_translation_on,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [63:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [63:0] o_rdata,
  // Fault outputs
  output logic o_fault,
  output logic [15:0] o_vector
);
  // Captured state
  logic [63:0] interruption_syndrome;
  logic [63:0] faulting_address;
  logic [63:0] hashed_entry_address;
  logic [63:0] default_translation_info;
  logic [15:0] vector;
  logic fault;
  logic [63:0] rdata;

  // Enabling conditions
  wire ic_on = (i_collection == tmfr_pkg::TMFR_IC_ON);
  wire ic_flight = (i_collection == tmfr_pkg::TMFR_IC_FLIGHT);
  wire ic_ok = ic_on || ic_flight;
  wire walker = i_region.walker_en;
  wire instr_req = i_req.valid && i_req.is_instr;
  wire d_miss = i_req.valid && !i_req.is_instr;
  wire d_kind = i_req.is_load || i_req.is_store || i_req.is_sema || i_req.is_nonaccess;
  wire instr_walk = instr_req && walker && ic_ok && i_instr_translation_on
    && i_req.will_exec && i_req.walker_fail;
  wire instr_alt = instr_req && !walker && i_req.will_exec;
  wire d_ok_norm = !i_req.is_stack && d_kind && i_data_translation_on;
  wire d_ok_stack = i_req.is_stack && i_stack_translation_on;
  wire data_cand = d_miss && walker && i_req.walker_fail && (d_ok_norm || d_ok_stack);
  wire data_walk = data_cand && ic_ok;
  wire data_nest = data_cand && !ic_ok;
  wire take = instr_walk || instr_alt || data_walk || data_nest;

  // Vector choice
  wire [15:0] next_vector = instr_walk ? tmfr_pkg::VEC_INSTR_MISS :
    instr_alt ? tmfr_pkg::VEC_ALT_INSTR :
    data_walk ? tmfr_pkg::VEC_DATA_MISS :
    tmfr_pkg::VEC_NESTED_DATA;

  // Faulting address
  wire [63:0] legacy_addr = i_req.vaddr & tmfr_pkg::LEGACY_ALIGN_MASK
    & tmfr_pkg::LEGACY_ADDR_MASK;
  wire [63:0] next_fault_addr = (i_req.is_instr && i_req.legacy) ? legacy_addr
    : i_req.vaddr;

  // Default translation info: key and page size only
  wire [63:0] next_dti = (64'(i_region.region_id) << tmfr_pkg::DTI_KEY_LO)
    | (64'(i_region.region_page_size) << tmfr_pkg::DTI_PS_LO);

  // Syndrome assembly
  wire ni_val = instr_alt ? !ic_on : (i_collection == tmfr_pkg::TMFR_IC_FLIGHT);
  wire native = !i_req.legacy;
  logic [63:0] next_syn;
  always_comb begin
    next_syn = 64'h0;
    if (i_req.is_instr) begin
      next_syn[tmfr_pkg::SYN_X] = 1'b1;
      if (native) begin
        next_syn[tmfr_pkg::SYN_EI_LO +: 2] = i_req.slot;
        next_syn[tmfr_pkg::SYN_NI] = ni_val;
      end
    end else begin
      next_syn[tmfr_pkg::SYN_W] = i_req.is_store || i_req.is_sema;
      next_syn[tmfr_pkg::SYN_R] = i_req.is_load || i_req.is_sema;
      next_syn[tmfr_pkg::SYN_NI] = ni_val;
      if (native) begin
        if (i_req.is_nonaccess) begin
          next_syn[tmfr_pkg::SYN_CODE_LO +: 4] = i_req.na_code;
        end
        next_syn[tmfr_pkg::SYN_NA] = i_req.is_nonaccess;
        next_syn[tmfr_pkg::SYN_SP] = i_req.speculative;
        next_syn[tmfr_pkg::SYN_RS] = i_req.is_stack;
        next_syn[tmfr_pkg::SYN_EI_LO +: 2] = i_req.slot;
        next_syn[tmfr_pkg::SYN_ED] = 1'b0;
      end // Legacy leaves all of these zero
    end
  end

  // Register decode
  wire wr_syn = i_wr && (i_addr == tmfr_pkg::REG_SYNDROME);
  wire wr_fa = i_wr && (i_addr == tmfr_pkg::REG_FAULT_ADDR);
  wire wr_ha = i_wr && (i_addr == tmfr_pkg::REG_HASHED_ADDR);
  wire wr_dti = i_wr && (i_addr == tmfr_pkg::REG_DEF_TRANS);
  wire walk_fault = instr_walk || data_walk || data_nest;
  wire [63:0] rd_mux = (i_addr == tmfr_pkg::REG_SYNDROME) ? interruption_syndrome :
    (i_addr == tmfr_pkg::REG_FAULT_ADDR) ? faulting_address :
    (i_addr == tmfr_pkg::REG_HASHED_ADDR) ? hashed_entry_address :
    (i_addr == tmfr_pkg::REG_DEF_TRANS) ? default_translation_info :
    (i_addr == tmfr_pkg::REG_VECTOR) ? 64'(vector) :
    (i_addr == tmfr_pkg::REG_STATUS) ? 64'(fault) : 64'h0;

  // Capture; a fault wins over a software write in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      interruption_syndrome <= 64'h0;
      faulting_address <= 64'h0;
      hashed_entry_address <= 64'h0;
      default_translation_info <= 64'h0;
      vector <= 16'h0;
      fault <= 1'b0;
      rdata <= 64'h0;
    end else begin
      fault <= take;
      rdata <= i_rd ? rd_mux : 64'h0;
      if (take) begin
        interruption_syndrome <= next_syn;
        faulting_address <= next_fault_addr;
        default_translation_info <= next_dti;
        vector <= next_vector;
      end else begin
        if (wr_syn) interruption_syndrome <= i_wdata;
        if (wr_fa) faulting_address <= i_wdata;
        if (wr_dti) default_translation_info <= i_wdata;
      end
      if (walk_fault) begin
        hashed_entry_address <= i_req.hash_addr;
      end else if (wr_ha) begin
        hashed_entry_address <= i_wdata;
      end
    end
  end

  assign o_rdata = rdata;
  assign o_fault = fault;
  assign o_vector = vector;

  // Checks
  vec_instr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    instr_walk |=> o_fault && o_vector == tmfr_pkg::VEC_INSTR_MISS)
    else $error("instruction miss vector wrong");
  vec_data_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    data_walk |=> o_vector == tmfr_pkg::VEC_DATA_MISS)
    else $error("data miss vector wrong");
  vec_alt_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    instr_alt |=> o_vector == tmfr_pkg::VEC_ALT_INSTR)
    else $error("alternate vector wrong");
  hash_load_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    walk_fault |=> hashed_entry_address == $past(i_req.hash_addr))
    else $error("hashed address not loaded");
  dti_key_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    take |=> default_translation_info[tmfr_pkg::DTI_KEY_LO +: 24] == $past(i_region.region_id))
    else $error("key field wrong");
  exec_bit_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    take |=> interruption_syndrome[tmfr_pkg::SYN_X] == $past(i_req.is_instr))
    else $error("execute bit wrong");
  legacy_addr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (take && i_req.is_instr && i_req.legacy) |=> faulting_address[3:0] == 4'h0
      && faulting_address[63:32] == 32'h0)
    else $error("legacy address not aligned");
  ni_flight_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (walk_fault && native && i_collection == tmfr_pkg::TMFR_IC_FLIGHT)
      |=> interruption_syndrome[tmfr_pkg::SYN_NI])
    else $error("not collected bit wrong");
  legacy_data_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (take && !i_req.is_instr && i_req.legacy)
      |=> interruption_syndrome[tmfr_pkg::SYN_ED:tmfr_pkg::SYN_NI + 1] == 4'h0
      && interruption_syndrome[tmfr_pkg::SYN_NI - 1:tmfr_pkg::SYN_NA] == 4'h0
      && interruption_syndrome[tmfr_pkg::SYN_CODE_LO +: 4] == 4'h0)
    else $error("legacy data syndrome not clear");
  nested_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (data_cand && i_collection == tmfr_pkg::TMFR_IC_OFF)
      |=> o_vector == tmfr_pkg::VEC_NESTED_DATA)
    else $error("nested fault not taken");
  cov_instr_c: cover property (@(posedge i_clk_sys) instr_walk);
  cov_alt_c: cover property (@(posedge i_clk_sys) instr_alt);
  cov_data_c: cover property (@(posedge i_clk_sys) data_walk && i_req.is_nonaccess);
  cov_nest_c: cover property (@(posedge i_clk_sys) data_nest);
endmodule : tmfr_fault

/* File: tmfr_pipe_model.sv */
// Pipeline and walker stand-in: presents one miss request per bench command.
// Assumes the bench sets walker_fail for any walker failure reason.
`timescale 1ns/1ns
module tmfr_pipe_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Commands from the bench
  input wire logic i_send,
  input wire tmfr_pkg::tmfr_req_t i_next,
  input wire tmfr_pkg::tmfr_region_t i_next_region,
  // Toward the fault unit
  output tmfr_pkg::tmfr_req_t o_req,
  output tmfr_pkg::tmfr_region_t o_region
);
  // One-cycle request; idle cycles scramble stale fields
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_req <= '0;
      o_region <= '0;
    end else if (i_send) begin
      o_req <= i_next;
      o_region <= i_next_region;
    end else begin
      o_req <= {1'b0, ~o_req[$bits(o_req)-2:0]};
      o_region <= ~o_region;
    end
  end
endmodule : tmfr_pipe_model

/* File: testbench.sv */
// Self-checking bench for the fault unit: random miss requests from a fixed seed.
// Assumes the package, fault unit and pipeline model are compiled first.
`timescale 1ns/1ns
module testbench;
  logic i_clk_sys, i_rst_n, send, wr, rd, it, dt, rt, o_fault, syn_ok;
  logic [3:0] addr;
  logic [63:0] wdata, rdata, syn, fad, hsh, dti, got;
  logic [15:0] o_vector, lastv, v;
  tmfr_pkg::tmfr_req_t nreq, req;
  tmfr_pkg::tmfr_region_t nrgn, rgn;
  tmfr_pkg::tmfr_ic_t ic;
  integer seed = 32'h8c49;
  int fail_count = 0;
  int checks = 0;
  tmfr_pipe_model u_tmfr_pipe_model (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_send(send),
    .i_next(nreq), .i_next_region(nrgn), .o_req(req), .o_region(rgn));
  tmfr_fault u_tmfr_fault (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(req), .i_region(rgn),
    .i_collection(ic), .i_instr_translation_on(it), .i_data_translation_on(dt),
    .i_stack_translation_on(rt), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_fault(o_fault), .o_vector(o_vector));
  // Clock
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // Expected vector, zero when no fault
  function automatic logic [15:0] exp_vec(input tmfr_pkg::tmfr_req_t r,
                                          input tmfr_pkg::tmfr_region_t g);
    if (r.is_instr && !g.walker_en) return r.will_exec ? tmfr_pkg::VEC_ALT_INSTR : 16'h0000;
    if (!g.walker_en || !r.walker_fail) return 16'h0000;
    if (r.is_instr) return (ic != tmfr_pkg::TMFR_IC_OFF && it && r.will_exec) ?
      tmfr_pkg::VEC_INSTR_MISS : 16'h0000;
    if (r.is_stack ? !rt : !dt) return 16'h0000;
    return (ic == tmfr_pkg::TMFR_IC_OFF) ? tmfr_pkg::VEC_NESTED_DATA : tmfr_pkg::VEC_DATA_MISS;
  endfunction : exp_vec
  // Expected syndrome
  function automatic logic [63:0] exp_syn(input tmfr_pkg::tmfr_req_t r);
    logic [63:0] s;
    s = 64'h0;
    if (r.is_instr) begin
      s[tmfr_pkg::SYN_X] = 1'b1;
      if (!r.legacy) begin
        s[tmfr_pkg::SYN_EI_LO +: 2] = r.slot;
        s[tmfr_pkg::SYN_NI] = (ic != tmfr_pkg::TMFR_IC_ON);
      end
    end else begin
      s[tmfr_pkg::SYN_R] = r.is_load | r.is_sema;
      s[tmfr_pkg::SYN_W] = r.is_store | r.is_sema;
      s[tmfr_pkg::SYN_NI] = (ic == tmfr_pkg::TMFR_IC_FLIGHT);
      if (!r.legacy) begin
        s[3:0] = r.is_nonaccess ? r.na_code : 4'h0;
        s[tmfr_pkg::SYN_NA] = r.is_nonaccess;
        s[tmfr_pkg::SYN_SP] = r.speculative;
        s[tmfr_pkg::SYN_RS] = r.is_stack;
      end
    end
    return s;
  endfunction : exp_syn
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rd_reg(input logic [3:0] a, output logic [63:0] d);
    @(posedge i_clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge i_clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic wr_reg(input logic [3:0] a, input logic [63:0] d);
    @(posedge i_clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clk_sys);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic chk_regs;
    rd_reg(tmfr_pkg::REG_SYNDROME, got);
    if (syn_ok) chk(got, syn);
    rd_reg(tmfr_pkg::REG_FAULT_ADDR, got);
    chk(got, fad);
    rd_reg(tmfr_pkg::REG_HASHED_ADDR, got);
    chk(got, hsh);
    rd_reg(tmfr_pkg::REG_DEF_TRANS, got);
    chk(got, dti);
    rd_reg(tmfr_pkg::REG_VECTOR, got);
    chk(got, {48'h0, lastv});
  endtask : chk_regs
  // One random miss request through the pipeline model
  task automatic fire;
    tmfr_pkg::tmfr_req_t r;
    tmfr_pkg::tmfr_region_t g;
    logic [31:0] x, y;
    x = $random(seed);
    y = $random(seed);
    r = '0;
    r.valid = 1'b1;
    r.is_instr = x[0];
    r.legacy = x[1];
    r.vaddr = {$random(seed), $random(seed)};
    r.hash_addr = {$random(seed), $random(seed)};
    r.walker_fail = x[2] | x[3];
    r.will_exec = x[4] | x[5];
    r.slot = x[0] ? (x[7] ? 2'h2 : {1'b0, x[6]}) : 2'h0;
    r.is_load = !x[0] && x[9:8] == 2'h0;
    r.is_store = !x[0] && x[9:8] == 2'h1;
    r.is_sema = !x[0] && x[9:8] == 2'h2;
    r.is_nonaccess = !x[0] && x[9:8] == 2'h3;
    r.na_code = x[13:10];
    r.is_stack = !x[0] && !x[9] && x[14];
    r.speculative = !x[0] && x[15];
    if (r.legacy && !r.is_instr) r.vaddr[63:32] = 32'h0;
    g = {y[23:0], y[29:24], y[30] | y[31]};
    @(posedge i_clk_sys);
    send <= 1'b1;
    nreq <= r;
    nrgn <= g;
    ic <= (x[17:16] == 2'h3) ? tmfr_pkg::TMFR_IC_ON : tmfr_pkg::tmfr_ic_t'(x[17:16]);
    it <= g.walker_en ? x[18] | x[19] : 1'b1;
    dt <= r.is_stack | x[20] | x[21];
    rt <= x[22];
    @(posedge i_clk_sys);
    send <= 1'b0;
    @(posedge i_clk_sys);
    #1 v = exp_vec(r, g);
    chk(o_fault, v != 16'h0000);
    if (v != 16'h0000) begin
      lastv = v;
      syn = exp_syn(r);
      syn_ok = 1'b1;
      fad = (r.is_instr && r.legacy) ?
        r.vaddr & tmfr_pkg::LEGACY_ADDR_MASK & tmfr_pkg::LEGACY_ALIGN_MASK : r.vaddr;
      dti = {32'h0, g.region_id, g.region_page_size, 2'h0};
      if (v != tmfr_pkg::VEC_ALT_INSTR) hsh = r.hash_addr;
    end
    chk(o_vector, lastv);
    chk_regs;
  endtask : fire
  task automatic end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  // Watchdog
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    fail_count++;
    end_of_test;
  end
  // Main sequence
  initial begin
    {i_rst_n, send, wr, rd, dt, rt, syn_ok, it} = 8'h0f;
    {addr, wdata, nreq, nrgn, syn, fad, hsh, dti, lastv} = '0;
    ic = tmfr_pkg::TMFR_IC_ON;
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    chk_regs;
    chk(o_vector, 64'h0);
    syn = {$random(seed), $random(seed)};
    wr_reg(tmfr_pkg::REG_SYNDROME, syn);
    wr_reg(4'h9, syn);
    rd_reg(4'h9, got);
    chk(got, 64'h0);
    wr_reg(tmfr_pkg::REG_VECTOR, syn);
    chk_regs;
    chk(o_vector, 64'h0);
    repeat (300) fire;
    end_of_test;
  end
endmodule : testbench
